// *** rcrf_regs.vh ***
/*
 * Constants of the remote command request framer: frame layout, option
 * bits, response layout and the register map of the APB slave.
 * Assumes it is included by bare name from the framer source.
 */
`ifndef RCRF_REGS_VH
`define RCRF_REGS_VH

// Frame bytes
`define RCRF_SOF          8'h7e
`define RCRF_TYPE_REQ     8'h17
`define RCRF_TYPE_RSP     8'h97
`define RCRF_CSUM_BASE    8'hff
`define RCRF_SUM_RST      8'h00

// Absolute byte offsets within a request frame
`define RCRF_OFS_TYPE     16'd3
`define RCRF_OFS_ID       16'd4
`define RCRF_OFS_DEST     16'd5
`define RCRF_OFS_DEST_END 16'd12
`define RCRF_OFS_OPT      16'd15
`define RCRF_OFS_CMD_HI   16'd16
`define RCRF_OFS_CMD_LO   16'd17
`define RCRF_OFS_VAL      16'd18
`define RCRF_END_ADJ      17'd2
`define RCRF_LEN_MIN      16'd15
`define RCRF_LEN_ZERO     16'h0000

// Option bit positions
`define RCRF_OPT_NOACK    0
`define RCRF_OPT_APPLY    1
`define RCRF_OPT_SECURE   4

// Command that commits queued changes, two ASCII characters
`define RCRF_CMD_APPLY    16'h4143
`define RCRF_ID_NONE      8'h00

// Response frame: 7e, length, type, id, command, status, checksum
`define RCRF_RSP_LEN      16'h0005
`define RCRF_RSP_LAST     4'd8
`define RCRF_IDX_LEN_HI   4'd1
`define RCRF_IDX_LEN_LO   4'd2
`define RCRF_IDX_TYPE     4'd3
`define RCRF_IDX_ID       4'd4
`define RCRF_IDX_CMD_HI   4'd5
`define RCRF_IDX_CMD_LO   4'd6
`define RCRF_IDX_STATUS   4'd7

// APB register map, byte addresses
`define RCRF_ADDR_CTRL    8'h00
`define RCRF_ADDR_STATUS  8'h04
`define RCRF_ADDR_COUNT   8'h08
`define RCRF_ADDR_LAST    8'h0c
`define RCRF_CTRL_EN      0
`define RCRF_CTRL_CLR     1
`define RCRF_CTRL_EN_RST  1'b1
`define RCRF_CNT_ONE      16'h0001
`define RCRF_CNT_RST      16'h0000
`define RCRF_WORD_RST     32'h00000000

`endif

// *** rcrf_framer.v ***
/*
 * Remote command request framer: parses request frames from the host byte
 * stream, hands checked requests to the frame handler, tracks queued changes
 * and builds the short response frame. APB slave for control and status.
 * Assumes rx bytes and the handler run on pclk; tx sink obeys valid/ready.
 */
// Local design decisions: the APB slave port and the placing of the registers.
// Overview of operation
// - Only frames of type 0x17 are parsed as remote parameter requests.
// - A zero correlation id suppresses the response frame completely.
// - The 0x97 response carries the request's correlation id.
// - No value bytes after the command code means a parameter read.
// - Value bytes from offset 18 onward are the new parameter setting.
// - Command code is two ASCII bytes at offsets 16 and 17.
// - Option bit 0 asks for sending without acknowledgment.
// - Option bit 1 applies at once; otherwise change waits for apply.
// - Option bit 4 sends the remote command over the secured path.
// - Checksum is 0xFF minus low byte of sum from offset 3.
// - Length counts exactly the bytes between length and checksum.
// - Every frame starts with the delimiter byte 7E.
// - Response goes out at once, with no added delay; here it waits for the handler's rsp_valid status and starts the cycle after.
// - Change with options 0x00 stays queued until apply or store; here only apply clears change_pending, store is not decoded.
`timescale 1ns/100ps
`include "rcrf_regs.vh"
`default_nettype none

module rcrf_framer #(
    parameter MAX_VAL = 16,
    parameter AW      = 8
) (
    input  wire                 pclk,
    input  wire                 presetn,
    input  wire                 psel,
    input  wire                 penable,
    input  wire                 pwrite,
    input  wire [AW-1:0]        paddr,
    input  wire [31:0]          pwdata,
    output reg  [31:0]          prdata,
    output reg                  pready,
    output reg                  pslverr,
    input  wire [7:0]           rx_data,
    input  wire                 rx_valid,
    output reg                  req_valid,
    output reg  [7:0]           req_id,
    output reg  [63:0]          req_dest,
    output reg  [15:0]          req_cmd,
    output reg                  req_write,
    output reg  [8*MAX_VAL-1:0] req_value,
    output reg  [7:0]           req_value_len,
    output reg                  req_no_ack,
    output reg                  req_apply,
    output reg                  req_secure,
    output reg                  apply_pending_changes_cmd,
    output reg                  change_pending,
    input  wire                 rsp_valid,
    input  wire [7:0]           rsp_status,
    output reg                  rsp_busy,
    output reg  [7:0]           tx_data,
    output reg                  tx_valid,
    input  wire                 tx_ready
);

    localparam ST_IDLE   = 3'd0;
    localparam ST_LEN_HI = 3'd1;
    localparam ST_LEN_LO = 3'd2;
    localparam ST_BODY   = 3'd3;
    localparam ST_CSUM   = 3'd4;

    localparam [15:0] LEN_MAX = `RCRF_LEN_MIN + MAX_VAL;
    localparam [15:0] RSP_LEN = `RCRF_RSP_LEN;

    reg  [2:0]           state;
    reg  [15:0]          flen;
    reg  [15:0]          pos;
    reg  [7:0]           sum;
    reg                  type_ok;
    reg  [7:0]           stage_id;
    reg  [63:0]          stage_dest;
    reg  [7:0]           stage_opt;
    reg  [15:0]          stage_cmd;
    reg  [8*MAX_VAL-1:0] stage_value;
    reg                  bad_evt;
    reg                  rsp_owed;
    reg  [7:0]           rsp_id;
    reg  [15:0]          rsp_cmd;
    reg  [7:0]           rsp_st;
    reg  [7:0]           rsp_csum;
    reg  [3:0]           tx_idx;
    reg                  ctrl_en;
    reg  [15:0]          good_cnt;
    reg  [15:0]          bad_cnt;
    reg  [7:0]           last_opt;

    wire [7:0]  csum_total = sum + rx_data;
    // Eight-bit sum keeps the response checksum free of carries and shift order
    wire [7:0]  rsp_sum    = `RCRF_TYPE_RSP + req_id + req_cmd[15:8] + req_cmd[7:0] + rsp_status;
    wire        len_ok     = (flen >= `RCRF_LEN_MIN) && (flen <= LEN_MAX);
    wire [15:0] val_len    = flen - `RCRF_LEN_MIN;
    wire [15:0] val_idx    = pos - `RCRF_OFS_VAL;
    wire [15:0] dest_idx   = `RCRF_OFS_DEST_END - pos;
    wire        body_last  = ({1'b0, pos} == ({1'b0, flen} + `RCRF_END_ADJ));
    wire        is_write   = (flen != `RCRF_LEN_MIN);
    wire        apply_now  = (is_write && stage_opt[`RCRF_OPT_APPLY]) ||
                             (stage_cmd == `RCRF_CMD_APPLY);
    wire        apb_wr     = psel && penable && pready && pwrite;
    wire        clr_cnt    = apb_wr && (paddr == `RCRF_ADDR_CTRL) &&
                             pwdata[`RCRF_CTRL_CLR];

    // Byte of the response frame at a given index
    function [7:0] rsp_byte;
        input [3:0]  idx;
        input [7:0]  id;
        input [15:0] cmd;
        input [7:0]  st;
        input [7:0]  cs;
        begin
            case (idx)
                `RCRF_IDX_LEN_HI: rsp_byte = RSP_LEN[15:8];
                `RCRF_IDX_LEN_LO: rsp_byte = RSP_LEN[7:0];
                `RCRF_IDX_TYPE:   rsp_byte = `RCRF_TYPE_RSP;
                `RCRF_IDX_ID:     rsp_byte = id;
                `RCRF_IDX_CMD_HI: rsp_byte = cmd[15:8];
                `RCRF_IDX_CMD_LO: rsp_byte = cmd[7:0];
                `RCRF_IDX_STATUS: rsp_byte = st;
                `RCRF_RSP_LAST:   rsp_byte = cs;
                default:          rsp_byte = `RCRF_SOF;
            endcase
        end
    endfunction

    // Receive parser
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= ST_IDLE;
            flen        <= `RCRF_LEN_ZERO;
            pos         <= `RCRF_LEN_ZERO;
            sum         <= `RCRF_SUM_RST;
            type_ok     <= 1'b0;
            stage_id    <= `RCRF_ID_NONE;
            stage_dest  <= {64{1'b0}};
            stage_opt   <= `RCRF_SUM_RST;
            stage_cmd   <= `RCRF_LEN_ZERO;
            stage_value <= {8*MAX_VAL{1'b0}};
            bad_evt     <= 1'b0;
        end else begin
            bad_evt <= 1'b0;
            if (!ctrl_en) begin
                state <= ST_IDLE;
            end else if (rx_valid) begin
                case (state)
                    ST_IDLE: begin
                        if (rx_data == `RCRF_SOF) begin
                            state <= ST_LEN_HI;
                        end
                    end
                    ST_LEN_HI: begin
                        flen[15:8] <= rx_data;
                        state      <= ST_LEN_LO;
                    end
                    ST_LEN_LO: begin
                        flen[7:0] <= rx_data;
                        pos       <= `RCRF_OFS_TYPE;
                        sum       <= `RCRF_SUM_RST;
                        type_ok   <= 1'b0;
                        // Empty body goes straight to the checksum
                        if ({flen[15:8], rx_data} == `RCRF_LEN_ZERO) begin
                            state <= ST_CSUM;
                        end else begin
                            state <= ST_BODY;
                        end
                    end
                    ST_BODY: begin
                        sum <= csum_total;
                        pos <= pos + 16'd1;
                        if (pos == `RCRF_OFS_TYPE) begin
                            type_ok <= (rx_data == `RCRF_TYPE_REQ);
                        end
                        if (pos == `RCRF_OFS_ID) begin
                            stage_id <= rx_data;
                        end
                        if (pos >= `RCRF_OFS_DEST && pos <= `RCRF_OFS_DEST_END) begin
                            stage_dest[dest_idx[2:0]*8 +: 8] <= rx_data;
                        end
                        if (pos == `RCRF_OFS_OPT) begin
                            stage_opt <= rx_data;
                        end
                        if (pos == `RCRF_OFS_CMD_HI) begin
                            stage_cmd[15:8] <= rx_data;
                        end
                        if (pos == `RCRF_OFS_CMD_LO) begin
                            stage_cmd[7:0] <= rx_data;
                        end
                        // Bytes beyond capacity are dropped; length check rejects such frames
                        if (pos >= `RCRF_OFS_VAL && val_idx < MAX_VAL) begin
                            stage_value[val_idx*8 +: 8] <= rx_data;
                        end
                        if (body_last) begin
                            state <= ST_CSUM;
                        end
                    end
                    ST_CSUM: begin
                        state <= ST_IDLE;
                        // Other frame types pass by uncounted
                        if (type_ok && !(len_ok && csum_total == `RCRF_CSUM_BASE)) begin
                            bad_evt <= 1'b1;
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Hand-over of a checked request and queued change tracking
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_valid                 <= 1'b0;
            req_id                    <= `RCRF_ID_NONE;
            req_dest                  <= {64{1'b0}};
            req_cmd                   <= `RCRF_LEN_ZERO;
            req_write                 <= 1'b0;
            req_value                 <= {8*MAX_VAL{1'b0}};
            req_value_len             <= `RCRF_SUM_RST;
            req_no_ack                <= 1'b0;
            req_apply                 <= 1'b0;
            req_secure                <= 1'b0;
            apply_pending_changes_cmd <= 1'b0;
            change_pending            <= 1'b0;
        end else begin
            req_valid                 <= 1'b0;
            apply_pending_changes_cmd <= 1'b0;
            if (ctrl_en && rx_valid && state == ST_CSUM && type_ok && len_ok &&
                csum_total == `RCRF_CSUM_BASE) begin
                req_valid     <= 1'b1;
                req_id        <= stage_id;
                req_dest      <= stage_dest;
                req_cmd       <= stage_cmd;
                req_write     <= is_write;
                req_value     <= stage_value;
                req_value_len <= val_len[7:0];
                req_no_ack    <= stage_opt[`RCRF_OPT_NOACK];
                req_apply     <= is_write && stage_opt[`RCRF_OPT_APPLY];
                req_secure    <= stage_opt[`RCRF_OPT_SECURE];
                if (apply_now) begin
                    apply_pending_changes_cmd <= 1'b1;
                    change_pending            <= 1'b0;
                end else if (is_write) begin
                    change_pending <= 1'b1;
                end
            end
        end
    end

    // Response builder; starts in the cycle after the handler's status
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp_owed <= 1'b0;
            rsp_busy <= 1'b0;
            rsp_id   <= `RCRF_ID_NONE;
            rsp_cmd  <= `RCRF_LEN_ZERO;
            rsp_st   <= `RCRF_SUM_RST;
            rsp_csum <= `RCRF_SUM_RST;
            tx_idx   <= 4'd0;
            tx_data  <= `RCRF_SUM_RST;
            tx_valid <= 1'b0;
        end else begin
            if (req_valid) begin
                rsp_owed <= (req_id != `RCRF_ID_NONE);
            end else if (rsp_valid && rsp_owed && !rsp_busy) begin
                rsp_owed <= 1'b0;
            end
            if (rsp_valid && rsp_owed && !rsp_busy && !req_valid) begin
                rsp_busy <= 1'b1;
                rsp_id   <= req_id;
                rsp_cmd  <= req_cmd;
                rsp_st   <= rsp_status;
                rsp_csum <= `RCRF_CSUM_BASE - rsp_sum;
                tx_data  <= `RCRF_SOF;
                tx_valid <= 1'b1;
                tx_idx   <= `RCRF_IDX_LEN_HI;
            end else if (tx_valid && tx_ready) begin
                if (tx_idx > `RCRF_RSP_LAST) begin
                    tx_valid <= 1'b0;
                    rsp_busy <= 1'b0;
                end else begin
                    tx_data <= rsp_byte(tx_idx, rsp_id, rsp_cmd, rsp_st, rsp_csum);
                    tx_idx  <= tx_idx + 4'd1;
                end
            end
        end
    end

    // APB slave; answers in the access cycle, no wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready   <= 1'b0;
            prdata   <= `RCRF_WORD_RST;
            pslverr  <= 1'b0;
            ctrl_en  <= `RCRF_CTRL_EN_RST;
            good_cnt <= `RCRF_CNT_RST;
            bad_cnt  <= `RCRF_CNT_RST;
            last_opt <= `RCRF_SUM_RST;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                case (paddr)
                    `RCRF_ADDR_CTRL:   prdata <= {31'h00000000, ctrl_en};
                    `RCRF_ADDR_STATUS: prdata <= {27'h0000000, state, rsp_busy,
                                                  change_pending};
                    `RCRF_ADDR_COUNT:  prdata <= {bad_cnt, good_cnt};
                    `RCRF_ADDR_LAST:   prdata <= {last_opt, req_id, req_cmd};
                    default: begin
                        prdata  <= `RCRF_WORD_RST;
                        pslverr <= 1'b1;
                    end
                endcase
            end
            if (apb_wr && paddr == `RCRF_ADDR_CTRL) begin
                ctrl_en <= pwdata[`RCRF_CTRL_EN];
            end
            if (req_valid) begin
                last_opt <= {3'b000, req_secure, 2'b00, req_apply, req_no_ack};
            end
            // Event wins over a clear in the same cycle
            if (req_valid) begin
                good_cnt <= clr_cnt ? `RCRF_CNT_ONE : good_cnt + `RCRF_CNT_ONE;
            end else if (clr_cnt) begin
                good_cnt <= `RCRF_CNT_RST;
            end
            if (bad_evt) begin
                bad_cnt <= clr_cnt ? `RCRF_CNT_ONE : bad_cnt + `RCRF_CNT_ONE;
            end else if (clr_cnt) begin
                bad_cnt <= `RCRF_CNT_RST;
            end
        end
    end

endmodule

`default_nettype wire

// *** rcrf_framer_asserts.sv ***
/* Port timing checker of the remote command request framer.
   Assumes one pclk domain and presetn asynchronous, active low. */
`timescale 1ns/100ps
`default_nettype none
module rcrf_framer_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        req_valid,
    input wire logic        req_write,
    input wire logic        req_apply,
    input wire logic [15:0] req_cmd,
    input wire logic        apply_pending_changes_cmd,
    input wire logic        change_pending,
    input wire logic        rsp_busy,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_valid,
    input wire logic        tx_ready
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    sequence s_change;
        req_valid && req_write && !req_apply && req_cmd != 16'h4143;
    endsequence
    apb_answer_a: assert property (s_setup |=> s_answer)
        else $error("apb answer not one access cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("slave error without ready");
    req_pulse_a: assert property (req_valid |=> !req_valid)
        else $error("request pulse too long");
    apply_now_a: assert property (req_valid && req_apply |-> apply_pending_changes_cmd)
        else $error("apply bit did not commit");
    apply_cmd_a: assert property (req_valid && req_cmd == 16'h4143 |-> apply_pending_changes_cmd)
        else $error("apply command did not commit");
    apply_cause_a: assert property (apply_pending_changes_cmd |->
        req_valid && (req_apply || req_cmd == 16'h4143))
        else $error("commit without cause");
    pending_clr_a: assert property (apply_pending_changes_cmd |=> !change_pending)
        else $error("pending change kept after commit");
    pending_set_a: assert property (s_change |-> ##[0:1] change_pending)
        else $error("queued change not pending");
    rsp_sof_a: assert property ($rose(rsp_busy) |-> tx_valid && tx_data == 8'h7e)
        else $error("response does not open with delimiter");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("response byte dropped while stalled");
    tx_in_rsp_a: assert property (tx_valid |-> rsp_busy)
        else $error("byte sent outside a response");
endmodule
bind rcrf_framer rcrf_framer_asserts i_chk (.pclk, .presetn, .psel, .penable, .pready,
    .pslverr, .req_valid, .req_write, .req_apply, .req_cmd, .apply_pending_changes_cmd,
    .change_pending, .rsp_busy, .tx_data, .tx_valid, .tx_ready);
`default_nettype wire

// *** rcrf_handler_model.sv ***
/* Frame handler and response sink model facing the framer.
   Assumes pclk domain; stat, dly and stall are set by the bench. */
`timescale 1ns/100ps
`default_nettype none
module rcrf_handler_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       req_valid,
    input  wire logic [7:0] stat,
    input  wire logic [7:0] dly,
    input  wire logic       stall,
    output var  logic       rsp_valid,
    output var  logic [7:0] rsp_status,
    output var  logic       tx_ready
);
    logic [8:0] cnt;
    // Answers the latest request, owed or not, so the framer must drop extras
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt        <= 9'h000;
            rsp_valid  <= 1'b0;
            rsp_status <= 8'h00;
            tx_ready   <= 1'b0;
        end else begin
            rsp_valid  <= 1'b0;
            rsp_status <= ~stat;
            tx_ready   <= stall ? ~tx_ready : 1'b1;
            if (req_valid) begin
                cnt <= {1'b0, dly} + 9'h001;
            end else if (cnt != 9'h000) begin
                cnt <= cnt - 9'h001;
                if (cnt == 9'h001) begin
                    rsp_valid  <= 1'b1;
                    rsp_status <= stat;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** test_rcrf_framer.sv ***
/* Self-checking bench of the remote command request framer.
   Assumes the framer, its constants header, handler model and checker. */
`timescale 1ns/100ps
`default_nettype none
`include "rcrf_regs.vh"
module test_rcrf_framer;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]   paddr, rx_data, req_id, req_value_len, rsp_status, tx_data, stat, dly;
    logic [31:0]  pwdata, prdata;
    logic         rx_valid, req_valid, req_write, req_no_ack, req_apply, req_secure;
    logic         apply_pending_changes_cmd, change_pending, rsp_valid, rsp_busy;
    logic         tx_valid, tx_ready, stall, dis;
    logic [63:0]  req_dest, e, g;
    logic [15:0]  req_cmd;
    logic [127:0] req_value;
    logic [63:0]  req_q[$];
    logic [7:0]   tx_q[$];
    integer       fail_count, comparisons, seed, cyc;

    rcrf_framer #(.MAX_VAL(16), .AW(8)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_data, .rx_valid, .req_valid,
        .req_id, .req_dest, .req_cmd, .req_write, .req_value, .req_value_len, .req_no_ack,
        .req_apply, .req_secure, .apply_pending_changes_cmd, .change_pending, .rsp_valid,
        .rsp_status, .rsp_busy, .tx_data, .tx_valid, .tx_ready);
    rcrf_handler_model i_host (.pclk, .presetn, .req_valid, .stat, .dly, .stall,
        .rsp_valid, .rsp_status, .tx_ready);

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic check(input string nm, input logic [63:0] ex, input logic [63:0] got);
        comparisons++;
        if (got !== ex) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic chk_req(input string nm, input logic [63:0] ex, input logic [63:0] got);
        check(nm, ex, got);
    endtask

    task automatic chk_tx(input logic [7:0] ex, input logic [7:0] got);
        check("response byte", {56'h0, ex}, {56'h0, got});
    endtask

    task automatic finish_test();
        // Expectations never met count as mismatches
        fail_count += req_q.size() + tx_q.size();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex, input logic er,
                          input logic w = 1'b0);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= ex;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        check("register", {31'h0, er, w ? 32'h0 : ex}, {31'h0, pslverr, w ? 32'h0 : prdata});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Host side framing; undefined option bits are only ever zero
    task automatic send(input logic [7:0] typ, opt, id, input logic [15:0] cmd,
                        input integer n, input logic bad);
        logic [7:0] b[$];
        logic [7:0] s;
        logic [7:0] v0;
        b = {typ, id, 8'h00, 8'h13, 8'ha2, 8'h00, 8'h12, 8'h34, 8'h56, 8'h78};
        b = {b, 8'hff, 8'hfe, opt, cmd[15:8], cmd[7:0]};
        for (int i = 0; i < n; i++) b.push_back(8'($random(seed)));
        s = 8'h00;
        foreach (b[i]) s += b[i];
        v0 = (n > 0) ? b[15] : 8'h00;
        b = {8'h55, `RCRF_SOF, 8'h00, 8'(b.size()), b, (8'hff - s) ^ {7'h00, bad}};
        foreach (b[i]) begin
            @(posedge pclk);
            rx_data <= b[i];
            rx_valid <= 1'b1;
        end
        // Noted only now, so a status set just before the call has settled
        if (!dis && typ == `RCRF_TYPE_REQ && !bad && n <= 16) begin
            req_q.push_back({8'h00, v0, 3'h0, opt[4], 2'h0, opt[1] && n > 0, opt[0],
                             8'(n), 7'h00, n > 0, id, cmd});
            if (id != 8'h00)
                tx_q = {tx_q, `RCRF_SOF, 8'h00, 8'h05, `RCRF_TYPE_RSP, id, cmd[15:8],
                        cmd[7:0], stat, 8'hff - (8'h97 + id + cmd[15:8] + cmd[7:0] + stat)};
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
        // Covers the handler's longest answer delay too
        for (int t = 0; t < 300 && (t < 20 || req_q.size() > 0 || tx_q.size() > 0
             || rsp_busy !== 1'b0); t++) @(posedge pclk);
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (req_valid === 1'b1) begin
            e = req_q.size() > 0 ? req_q.pop_front() : 64'hx;
            g = {8'h00, req_write ? req_value[7:0] : 8'h00, 3'h0, req_secure, 2'h0,
                 req_apply, req_no_ack, req_value_len, 7'h00, req_write, req_id, req_cmd};
            chk_req("request", e, g);
            chk_req("destination", 64'h0013a20012345678, req_dest);
        end
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            chk_tx(tx_q.size() > 0 ? tx_q.pop_front() : 8'hxx, tx_data);
        end
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        seed = 50;
        fail_count = 0;
        comparisons = 0;
        cyc = 0;
        dis = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, rx_data, rx_valid} = '0;
        {stat, dly, stall} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`RCRF_ADDR_CTRL, 32'h00000001, 1'b0);
        rd_chk(`RCRF_ADDR_COUNT, 32'h00000000, 1'b0);
        rd_chk(8'h10, 32'h00000000, 1'b1);
        rd_chk(8'h10, 32'h00000000, 1'b1, 1'b1);
        send(`RCRF_TYPE_REQ, 8'h00, 8'hfa, 16'h5450, 0, 1'b0);
        stat <= 8'h01;
        dly <= 8'h07;
        send(`RCRF_TYPE_REQ, 8'h02, 8'($random(seed)), 16'h4e49, 6, 1'b0);
        send(`RCRF_TYPE_REQ, 8'h00, 8'h00, 16'h4944, 2, 1'b0);
        rd_chk(`RCRF_ADDR_STATUS, 32'h00000001, 1'b0);
        send(`RCRF_TYPE_REQ, 8'h00, 8'($random(seed)), `RCRF_CMD_APPLY, 0, 1'b0);
        rd_chk(`RCRF_ADDR_STATUS, 32'h00000000, 1'b0);
        stall <= 1'b1;
        stat <= 8'($random(seed));
        dly <= 8'h00;
        send(`RCRF_TYPE_REQ, 8'h11, 8'($random(seed)), 16'h5450, 16, 1'b0);
        send(8'h08, 8'h00, 8'h21, 16'h5450, 0, 1'b0);
        send(`RCRF_TYPE_REQ, 8'h00, 8'h33, 16'h5450, 0, 1'b1);
        send(`RCRF_TYPE_REQ, 8'h02, 8'h44, 16'h4e49, 17, 1'b0);
        rd_chk(`RCRF_ADDR_COUNT, 32'h00020005, 1'b0);
        // Clear keeps enable; a frame while disabled must leave no trace
        rd_chk(`RCRF_ADDR_CTRL, 32'h00000003, 1'b0, 1'b1);
        rd_chk(`RCRF_ADDR_CTRL, 32'h00000000, 1'b0, 1'b1);
        rd_chk(`RCRF_ADDR_CTRL, 32'h00000000, 1'b0);
        dis = 1'b1;
        send(`RCRF_TYPE_REQ, 8'h00, 8'h66, 16'h5450, 0, 1'b0);
        dis = 1'b0;
        rd_chk(`RCRF_ADDR_CTRL, 32'h00000001, 1'b0, 1'b1);
        send(`RCRF_TYPE_REQ, 8'h10, 8'h5a, 16'h4e49, 1, 1'b0);
        rd_chk(`RCRF_ADDR_COUNT, 32'h00000001, 1'b0);
        finish_test();
    end
endmodule
`default_nettype wire
